// File: rtl/charge_seq_pkg.sv
// Purpose: Shared constants and types for the lithium cell charge sequencer.
// Assumes: A 50 MHz system clock.
// Notes:   Every timing count is derived here from a time in its own unit.
package charge_seq_pkg;

    // ********************************************************************
    // Clock and timing
    // ********************************************************************
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam int unsigned FAULT_PULSE_US    = 128;
    localparam int unsigned FAULT_PULSE_CYC   = (FAULT_PULSE_US * (CLK_HZ / 1_000_000));
    localparam int unsigned DETECT_US_DEFAULT = 32_000;
    localparam int unsigned DETECT_CYC_DEFAULT = DETECT_US_DEFAULT * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W             = 24;

    // ********************************************************************
    // Temperature fault field positions
    // ********************************************************************
    localparam int unsigned TEMP_COLD_BIT = 0;
    localparam int unsigned TEMP_COOL_BIT = 1;
    localparam int unsigned TEMP_WARM_BIT = 2;
    localparam int unsigned TEMP_HOT_BIT  = 3;
    localparam int unsigned TEMP_W        = 4;
    localparam logic [TEMP_W-1:0] TEMP_RESET = 4'h0;

    // ********************************************************************
    // Charge phases
    // ********************************************************************
    typedef enum logic [3:0] {
        PH_IDLE,
        PH_SHORT_RECOVERY,
        PH_CONDITION,
        PH_CONST_CURRENT,
        PH_CONST_VOLTAGE,
        PH_DETECT_SINK,
        PH_DETECT_SOURCE,
        PH_DONE
    } charge_phase_t;

endpackage : charge_seq_pkg

// File: rtl/pulse_timer.sv
// Purpose: Stretches a one-cycle trigger into a pulse of fixed length.
// Assumes: Trigger is synchronous to clk_sys_i.
// Notes:   A trigger during a pulse restarts the full length.
`timescale 1ns/1ps
`default_nettype none
module pulse_timer
    import charge_seq_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic trig_i,
    output logic      pulse_o
);
    import charge_seq_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // Counting the clock keeps the pulse exact and repeatable.
    always_comb begin
        nxt_cnt = cnt_ff;
        if (trig_i) begin
            nxt_cnt = CNT_W'(FAULT_PULSE_CYC);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - CNT_W'(1);
        end
    end

    // Register stage.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign pulse_o = (cnt_ff != '0);

    property p_pulse_len;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(pulse_o) && !trig_i |-> pulse_o [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("Pulse shorter than expected.");

    property p_pulse_end;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (cnt_ff == CNT_W'(1)) && !trig_i |=> !pulse_o;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("Pulse did not end on count.");

endmodule : pulse_timer
`default_nettype wire

// File: rtl/charge_sequencer.sv
// Purpose: Charge phase sequencer with status pin and fault pulse control.
// Assumes: Analog comparators arrive as clean levels synchronous to clk_sys_i.
// Notes:   Analog loops are outside; this block only selects and reports phases.
`timescale 1ns/1ps
`default_nettype none
module charge_sequencer
    import charge_seq_pkg::*;
#(
    parameter int unsigned DETECT_CYC = DETECT_CYC_DEFAULT
)(
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   power_present_i,
    input  wire logic                   input_above_uvlo_i,
    input  wire logic                   supply_above_sleep_i,
    input  wire logic                   charge_disable_i,
    input  wire logic                   end_of_charge_allow_bit_i,
    input  wire logic                   output_float_bit_i,
    input  wire logic                   reset_bit_i,
    input  wire logic                   status_gate_bit_i,
    input  wire logic                   hardware_disable_pin_i,
    input  wire logic                   bat_below_short_i,
    input  wire logic                   bat_above_detect_i,
    input  wire logic                   bat_below_recharge_i,
    input  wire logic                   bat_near_target_i,
    input  wire logic                   rail_above_level_i,
    input  wire logic                   rail_at_minimum_i,
    input  wire logic                   charge_current_zero_i,
    input  wire logic                   current_at_termination_i,
    input  wire logic                   die_over_temp_i,
    input  wire logic [TEMP_W-1:0]      temp_cross_i,
    input  wire logic                   fault_event_i,
    output logic                        stat_o,
    output logic                        stat_oe_o,
    output logic                        irq_o,
    output logic                        irq_oe_o,
    output logic                        gate_bias_supply_o,
    output charge_seq_pkg::charge_phase_t phase_o,
    output logic                        short_recovery_current_o,
    output logic                        program_current_o,
    output logic                        switch_linear_o,
    output logic                        switch_full_on_o,
    output logic                        taper_o,
    output logic                        hold_rail_o,
    output logic                        reduce_current_o,
    output logic                        supplement_o,
    output logic                        battery_absent_o,
    output logic                        disabled_mode_o,
    output logic [TEMP_W-1:0]           temp_fault_o
);
    import charge_seq_pkg::*;

    // ********************************************************************
    // Reset release
    // ********************************************************************
    logic rst_meta_ff;
    logic rst_sync_ff;

    // Two stages so that release never lands near a clock edge.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ********************************************************************
    // Restart event detection
    // ********************************************************************
    logic          power_q_ff, disable_q_ff, float_q_ff;
    logic          nxt_power_q, nxt_disable_q, nxt_float_q;
    logic          restart;
    logic          halted;

    // Remember last levels so any toggle is seen.
    always_comb begin
        nxt_power_q   = power_present_i;
        nxt_disable_q = charge_disable_i;
        nxt_float_q   = output_float_bit_i;
    end

    // Register stage.
    always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            power_q_ff   <= 1'b0;
            disable_q_ff <= 1'b0;
            float_q_ff   <= 1'b0;
        end else begin
            power_q_ff   <= nxt_power_q;
            disable_q_ff <= nxt_disable_q;
            float_q_ff   <= nxt_float_q;
        end
    end

    // Any listed event starts charging from the beginning unless it leaves the sequencer halted.
    assign restart = (power_present_i != power_q_ff) || (charge_disable_i != disable_q_ff)
                   || reset_bit_i || (output_float_bit_i != float_q_ff);
    assign disabled_mode_o = hardware_disable_pin_i || output_float_bit_i;
    assign halted = charge_disable_i || disabled_mode_o || !power_present_i;

    // ********************************************************************
    // Phase machine
    // ********************************************************************
    charge_phase_t    phase_ff, nxt_phase;
    logic [CNT_W-1:0] det_cnt_ff, nxt_det_cnt;
    logic             absent_ff, nxt_absent;
    logic             absent_evt;

    // Next phase; the detect counter times each detection half cycle.
    always_comb begin
        nxt_phase   = phase_ff;
        nxt_det_cnt = det_cnt_ff;
        nxt_absent  = absent_ff;
        absent_evt  = 1'b0;
        if (halted) begin
            nxt_phase   = PH_IDLE;
            nxt_det_cnt = '0;
            nxt_absent  = 1'b0;
        end else if (restart || phase_ff == PH_IDLE) begin
            nxt_phase   = bat_below_short_i ? PH_SHORT_RECOVERY : PH_CONDITION;
            nxt_det_cnt = '0;
        end else begin
            case (phase_ff)
                PH_SHORT_RECOVERY: begin
                    // Recovery current stays on for whole detect intervals until the battery is no longer below short.
                    nxt_det_cnt = det_cnt_ff + CNT_W'(1);
                    if (det_cnt_ff >= CNT_W'(DETECT_CYC - 1) && !bat_below_short_i) begin
                        nxt_phase   = PH_CONDITION;
                        nxt_det_cnt = '0;
                    end else if (det_cnt_ff >= CNT_W'(DETECT_CYC - 1)) begin
                        nxt_det_cnt = '0;
                    end
                end
                PH_CONDITION: begin
                    if (rail_above_level_i) begin
                        nxt_phase = PH_CONST_CURRENT;
                    end
                end
                PH_CONST_CURRENT: begin
                    if (bat_near_target_i) begin
                        nxt_phase = PH_CONST_VOLTAGE;
                    end
                end
                PH_CONST_VOLTAGE: begin
                    if (end_of_charge_allow_bit_i && current_at_termination_i
                        && !bat_below_recharge_i) begin
                        nxt_phase   = PH_DETECT_SINK;
                        nxt_det_cnt = '0;
                    end
                end
                PH_DETECT_SINK: begin
                    // Battery must stay above threshold the whole interval.
                    nxt_det_cnt = det_cnt_ff + CNT_W'(1);
                    if (!bat_above_detect_i) begin
                        nxt_phase   = PH_DETECT_SOURCE;
                        nxt_det_cnt = '0;
                        nxt_absent  = 1'b1;
                        absent_evt  = 1'b1;
                    end else if (det_cnt_ff >= CNT_W'(DETECT_CYC - 1)) begin
                        nxt_phase   = PH_DONE;
                        nxt_det_cnt = '0;
                        nxt_absent  = 1'b0;
                    end
                end
                PH_DETECT_SOURCE: begin
                    nxt_det_cnt = det_cnt_ff + CNT_W'(1);
                    if (det_cnt_ff >= CNT_W'(DETECT_CYC - 1)) begin
                        nxt_phase   = PH_DETECT_SINK;
                        nxt_det_cnt = '0;
                    end
                end
                PH_DONE: begin
                    if (bat_below_recharge_i) begin
                        nxt_phase = bat_below_short_i ? PH_SHORT_RECOVERY : PH_CONDITION;
                    end
                end
                default: begin
                    nxt_phase = PH_IDLE;
                end
            endcase
        end
    end

    // Register stage for the phase machine.
    always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            phase_ff   <= PH_IDLE;
            det_cnt_ff <= '0;
            absent_ff  <= 1'b0;
        end else begin
            phase_ff   <= nxt_phase;
            det_cnt_ff <= nxt_det_cnt;
            absent_ff  <= nxt_absent;
        end
    end

    // ********************************************************************
    // Phase outputs
    // ********************************************************************
    logic charging;
    logic on_current;

    assign charging   = (phase_ff != PH_IDLE) && (phase_ff != PH_DONE);
    assign on_current = (phase_ff == PH_CONDITION) || (phase_ff == PH_CONST_CURRENT)
                      || (phase_ff == PH_CONST_VOLTAGE);
    assign phase_o                  = phase_ff;
    assign short_recovery_current_o = (phase_ff == PH_SHORT_RECOVERY);
    assign program_current_o        = on_current && !charge_current_zero_i;
    assign switch_linear_o          = (phase_ff == PH_SHORT_RECOVERY) || (phase_ff == PH_CONDITION);
    assign switch_full_on_o         = (phase_ff == PH_CONST_CURRENT) || (phase_ff == PH_CONST_VOLTAGE)
                                    || supplement_o;
    assign taper_o                  = (phase_ff == PH_CONST_VOLTAGE);
    assign hold_rail_o              = (phase_ff == PH_SHORT_RECOVERY) || (phase_ff == PH_CONDITION)
                                    || (phase_ff == PH_DONE) || (phase_ff == PH_IDLE);
    // Overheat or a sagging rail trims current in every active phase.
    assign reduce_current_o         = charging && (die_over_temp_i || rail_at_minimum_i);
    assign supplement_o             = rail_at_minimum_i && charge_current_zero_i
                                    && power_present_i;
    assign battery_absent_o         = absent_ff;
    assign gate_bias_supply_o       = power_present_i && input_above_uvlo_i
                                    && supply_above_sleep_i;

    // ********************************************************************
    // Temperature faults and fault pulse
    // ********************************************************************
    logic [TEMP_W-1:0] temp_ff, nxt_temp;
    logic              pulse;
    logic              any_fault;

    // Each threshold crossing latches a fault bit until restart.
    always_comb begin
        nxt_temp = temp_ff;
        if (restart) begin
            nxt_temp = TEMP_RESET;
        end
        nxt_temp = nxt_temp | temp_cross_i;
    end

    // Register stage.
    always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            temp_ff <= TEMP_RESET;
        end else begin
            temp_ff <= nxt_temp;
        end
    end

    assign temp_fault_o = temp_ff;
    // A new temperature bit, a battery-absent finding or an outside fault triggers.
    assign any_fault = fault_event_i || absent_evt || ((temp_cross_i & ~temp_ff) != '0);

    pulse_timer u_pulse (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_sync_ff),
        .trig_i    (any_fault),
        .pulse_o   (pulse)
    );

    // Open drain: the pin is driven low only, and only when the gate allows.
    assign stat_o    = 1'b0;
    assign irq_o     = 1'b0;
    assign stat_oe_o = status_gate_bit_i && (pulse || (charging && !halted));
    assign irq_oe_o  = status_gate_bit_i && (pulse || (charging && !halted));

    // ********************************************************************
    // Checks
    // ********************************************************************
    property p_gate_off;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        !status_gate_bit_i |-> !stat_oe_o && !irq_oe_o;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("Status driven while gated off.");

    property p_disable_idle;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        charge_disable_i |=> phase_ff == PH_IDLE;
    endproperty
    a_disable_idle: assert property (p_disable_idle) else $error("Sequencer not idle when disabled.");

    property p_bias;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        gate_bias_supply_o |-> power_present_i && input_above_uvlo_i && supply_above_sleep_i;
    endproperty
    a_bias: assert property (p_bias) else $error("Gate bias on without supply.");

    property p_no_term;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        phase_ff == PH_CONST_VOLTAGE && !end_of_charge_allow_bit_i && !halted && !restart
        |=> phase_ff == PH_CONST_VOLTAGE;
    endproperty
    a_no_term: assert property (p_no_term) else $error("Terminated with termination off.");

    property p_absent;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        phase_ff == PH_DETECT_SINK && !bat_above_detect_i && !halted && !restart
        |=> phase_ff == PH_DETECT_SOURCE && battery_absent_o;
    endproperty
    a_absent: assert property (p_absent) else $error("Missing battery not flagged.");

    property p_stat_charge;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        status_gate_bit_i && charging && !halted |-> stat_oe_o;
    endproperty
    a_stat_charge: assert property (p_stat_charge) else $error("Status not low while charging.");

    property p_fault_pulse;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        fault_event_i |=> pulse [*8];
    endproperty
    a_fault_pulse: assert property (p_fault_pulse) else $error("Fault gave no pulse.");

    property p_temp_latch;
        @(posedge clk_sys_i) disable iff (!rst_sync_ff)
        temp_cross_i[TEMP_HOT_BIT] |=> temp_fault_o[TEMP_HOT_BIT];
    endproperty
    a_temp_latch: assert property (p_temp_latch) else $error("Hot fault not reported.");

    c_done:   cover property (@(posedge clk_sys_i) phase_ff == PH_DONE);
    c_short:  cover property (@(posedge clk_sys_i) phase_ff == PH_SHORT_RECOVERY);
    c_absent: cover property (@(posedge clk_sys_i) phase_ff == PH_DETECT_SOURCE);
    c_pulse:  cover property (@(posedge clk_sys_i) $rose(pulse));

endmodule : charge_sequencer
`default_nettype wire

// File: tb/host_watch.sv
// Purpose: Host side of the status pins: pull-ups and a pulse-length meter.
// Assumes: Enables are high while the charger pulls a pin low.
// Notes:   The meter counts clock edges that see the interrupt line low.
`timescale 1ns/1ps
`default_nettype none
module host_watch (
    input  wire logic        clk_sys_i,
    input  wire logic        stat_oe_i,
    input  wire logic        irq_oe_i,
    output logic             stat_line_o,
    output logic             irq_line_o,
    output logic [15:0]      low_len_o
);
    logic [15:0] run_ff = 16'h0000;

    // *****************************************************
    // Pin resolution and pulse meter
    // *****************************************************
    // The pull-ups win whenever nobody drives the line, so a released pin reads high.
    assign stat_line_o = stat_oe_i ? 1'b0 : 1'b1;
    assign irq_line_o  = irq_oe_i ? 1'b0 : 1'b1;

    // Each finished low run is kept until the next one ends.
    initial low_len_o = 16'h0000;
    always @(posedge clk_sys_i) begin
        if (!irq_line_o) begin
            run_ff <= run_ff + 16'h0001;
        end else begin
            if (run_ff != 16'h0000) begin
                low_len_o <= run_ff;
            end
            run_ff <= 16'h0000;
        end
    end
endmodule // host_watch
`default_nettype wire

// File: tb/li_ion_charge_sequencer_tb.sv
// Purpose: Self-checking bench for the charge sequencer.
// Assumes: A short detect interval of 16 cycles.
// Notes:   Inputs change by non-blocking assignment at a rising edge or 1 ns after it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin failures++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module li_ion_charge_sequencer_tb;
    import charge_seq_pkg::*;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
    logic pw = 1'b1, uv = 1'b1, sl = 1'b1, dis = 1'b0, allow = 1'b1, flt = 1'b0, rb = 1'b0;
    logic gate = 1'b1, hw = 1'b0, shrt = 1'b0, det = 1'b0, rch = 1'b0, near = 1'b0, rail = 1'b0;
    logic mins = 1'b0, zero = 1'b0, term = 1'b0, hot = 1'b0, fev = 1'b0;
    logic [TEMP_W-1:0] tc = 4'h0;
    logic stat, stat_oe, irq, irq_oe, gbs, src, pc, lin, full, tap, hold, red, sup, absent, dmode;
    logic stat_line, irq_line;
    logic [15:0] low_len;
    logic [TEMP_W-1:0] tf;
    charge_phase_t ph;
    int failures = 0, samples_checked = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    charge_sequencer #(.DETECT_CYC(16)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .power_present_i(pw), .input_above_uvlo_i(uv), .supply_above_sleep_i(sl),
        .charge_disable_i(dis), .end_of_charge_allow_bit_i(allow), .output_float_bit_i(flt),
        .reset_bit_i(rb), .status_gate_bit_i(gate), .hardware_disable_pin_i(hw),
        .bat_below_short_i(shrt), .bat_above_detect_i(det), .bat_below_recharge_i(rch),
        .bat_near_target_i(near), .rail_above_level_i(rail), .rail_at_minimum_i(mins),
        .charge_current_zero_i(zero), .current_at_termination_i(term), .die_over_temp_i(hot),
        .temp_cross_i(tc), .fault_event_i(fev), .stat_o(stat), .stat_oe_o(stat_oe), .irq_o(irq),
        .irq_oe_o(irq_oe), .gate_bias_supply_o(gbs), .phase_o(ph), .short_recovery_current_o(src),
        .program_current_o(pc), .switch_linear_o(lin), .switch_full_on_o(full), .taper_o(tap),
        .hold_rail_o(hold), .reduce_current_o(red), .supplement_o(sup),
        .battery_absent_o(absent), .disabled_mode_o(dmode), .temp_fault_o(tf));

    host_watch host (.clk_sys_i(clk_sys_i), .stat_oe_i(stat_oe), .irq_oe_i(irq_oe),
        .stat_line_o(stat_line), .irq_line_o(irq_line), .low_len_o(low_len));

    // *****************************************************
    // Shared tasks
    // *****************************************************
    // The verdict is printed from here only, so a hang and a normal end agree.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Waits a bounded number of edges for a phase; running out is a mismatch.
    task automatic wait_phase(input charge_phase_t p, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (ph === p) return;
        end
        failures++;
        $display("[FAIL] phase expected %0h seen %0h", p, ph);
        finish_test();
    endtask

    // One fault event. A driving pin is followed until released; a gated one is
    // waited out for the full pulse, since the hidden pulse would still drive the
    // pins once the gate opens again.
    task automatic fault_pulse(input logic drives);
        int i;
        @(posedge clk_sys_i);
        fev <= 1'b1;
        @(posedge clk_sys_i);
        fev <= 1'b0;
        #1;
        `CHK("irq_oe", drives, irq_oe)
        for (i = 0; i < 7000 && (drives ? (irq_line !== 1'b1) : (i < FAULT_PULSE_CYC + 4)); i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        repeat (3) @(posedge clk_sys_i);
        if (irq_line !== 1'b1) begin
            failures++;
            $display("[FAIL] irq_line expected 1 seen %0h", irq_line);
            finish_test();
        end
    endtask

    // *****************************************************
    // Main sequence
    // *****************************************************
    initial begin
        int i;
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys_i);
            {pw, uv, sl} <= 3'(i);
            #1;
            `CHK("gate_bias", &(3'(i)), gbs)
        end
        wait_phase(PH_CONDITION, 20);
        `CHK("stat_line", 1'b0, stat_line)
        `CHK("program_current", 1'b1, pc)
        `CHK("switch_linear", 1'b1, lin)
        @(posedge clk_sys_i);
        hot <= 1'b1;
        #1;
        `CHK("reduce_current", 1'b1, red)
        @(posedge clk_sys_i);
        hot <= 1'b0;
        rail <= 1'b1;
        wait_phase(PH_CONST_CURRENT, 4);
        `CHK("switch_full_on", 1'b1, full)
        near <= 1'b1;
        wait_phase(PH_CONST_VOLTAGE, 4);
        `CHK("taper", 1'b1, tap)
        allow <= 1'b0;
        term <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        #1;
        `CHK("phase_no_term", PH_CONST_VOLTAGE, ph)
        allow <= 1'b1;
        wait_phase(PH_DETECT_SINK, 4);
        det <= 1'b1;
        wait_phase(PH_DONE, 40);
        `CHK("stat_released", 1'b1, stat_line)
        `CHK("hold_rail", 1'b1, hold)
        fault_pulse(1'b1);
        `CHK("pulse_len", 16'(FAULT_PULSE_CYC), low_len)
        gate <= 1'b0;
        fault_pulse(1'b0);
        gate <= 1'b1;
        {rail, near, term} <= 3'h0;
        rch <= 1'b1;
        wait_phase(PH_CONDITION, 20);
        rch <= 1'b0;
        dis <= 1'b1;
        wait_phase(PH_IDLE, 4);
        `CHK("stat_oe_idle", 1'b0, stat_oe)
        dis <= 1'b0;
        wait_phase(PH_CONDITION, 20);
        hw <= 1'b1;
        #1;
        wait_phase(PH_IDLE, 4);
        `CHK("disabled_mode", 1'b1, dmode)
        hw <= 1'b0;
        tc <= 4'h8;
        @(posedge clk_sys_i);
        tc <= 4'h0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        `CHK("temp_fault", 4'h8, tf)
        // Let the temperature pulse run out so the later absent pulse is seen alone.
        repeat (FAULT_PULSE_CYC) @(posedge clk_sys_i);
        {mins, zero} <= 2'h3;
        @(posedge clk_sys_i);
        #1;
        `CHK("supplement", 1'b1, sup)
        `CHK("full_on_supplement", 1'b1, full)
        `CHK("reduce_rail", 1'b1, red)
        `CHK("program_current_zero", 1'b0, pc)
        {mins, zero} <= 2'h0;
        {shrt, rb} <= 2'h3;
        @(posedge clk_sys_i);
        rb <= 1'b0;
        wait_phase(PH_SHORT_RECOVERY, 4);
        `CHK("short_current", 1'b1, src)
        `CHK("short_linear", 1'b1, lin)
        `CHK("short_rail", 1'b1, hold)
        shrt <= 1'b0;
        wait_phase(PH_CONDITION, 20);
        {rail, near, term, det} <= 4'hE;
        wait_phase(PH_DETECT_SINK, 6);
        wait_phase(PH_DETECT_SOURCE, 4);
        `CHK("battery_absent", 1'b1, absent)
        det <= 1'b1;
        wait_phase(PH_DETECT_SINK, 20);
        wait_phase(PH_DONE, 20);
        `CHK("absent_cleared", 1'b0, absent)
        `CHK("absent_pulse", 1'b0, irq_line)
        `CHK("pin_data", 2'h0, {stat, irq})
        finish_test();
    end
endmodule // li_ion_charge_sequencer_tb
`default_nettype wire
